// ==== hw/host_frame_queue_access.sv ====
// Purpose: Host access to receive and transmit frame queues
// Assumes: Host strobes last one cycle and share sys_clk_in
// Notes: Receive words pass through an 8-word FIFO; tx status is queued too
`timescale 1ns/100ps

// Simple synchronous FIFO with valid/ready on both sides
module word_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input wire logic clk_in, // Clock
    input wire logic reset_in, // Synchronous reset
    input wire logic in_valid_in, // Write request
    output logic in_ready_out, // Room available
    input wire logic [WIDTH-1:0] in_data_in, // Write data
    output logic out_valid_out, // Data available
    input wire logic out_ready_in, // Pop request
    output logic [WIDTH-1:0] out_data_out, // Head word
    output logic [$clog2(DEPTH+1)-1:0] count_out // Fill level
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH]; // Storage
    logic [PW-1:0] wp_r; // Write pointer
    logic [PW-1:0] rp_r; // Read pointer
    logic [$clog2(DEPTH+1)-1:0] cnt_r; // Entries held
    logic push;
    logic pop;
    assign in_ready_out = (cnt_r != DEPTH[$clog2(DEPTH+1)-1:0]);
    assign out_valid_out = (cnt_r != '0);
    assign push = in_valid_in && in_ready_out;
    assign pop = out_ready_in && out_valid_out;
    assign out_data_out = mem_r[rp_r];
    assign count_out = cnt_r;
    // Storage write, no reset needed on data
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_r[wp_r] <= in_data_in;
        end
    end
    // Pointers and level
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= rp_r + 1'b1;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule // word_fifo

// Behaviour
// - Status low half counts head frame bytes
// - Byte count only grows while receiving
// - Done bit set after last byte
// - Done frame status popped on read
// - Data reads give words, zero padded
// - Excess bytes dropped, overrun pulse
// - Early control write aborts, underrun pulse
// - Length rewrite sets remaining byte count
// - Egress status queued with frame id
// - Setup count decrements per data write
// - Start and end offsets drop bytes
// - End offset applies while count zero
// - Endian bit picks first sent byte
// - Mode zero: ready on any block
// - Mode one: ready above threshold
// - Mode two: ready on whole frame
// - Mode three: frame or above threshold
// - Interrupt when blocks drop below threshold
// - Lowest numbered ready queue selected
module host_frame_queue_access (
    input wire logic sys_clk_in, // 25 MHz clock
    input wire logic reset_in, // Synchronous reset
    input wire logic host_wr_in, // Write strobe, one cycle
    input wire logic host_rd_in, // Read strobe, one cycle
    input wire logic [7:0] host_addr_in, // Byte address
    input wire logic [31:0] host_wdata_in, // Write data
    output logic [31:0] host_rdata_out, // Read data
    output logic host_rvalid_out, // Read data valid pulse
    input wire logic rx_byte_valid_in, // Received byte present
    input wire logic [7:0] rx_byte_in, // Received byte
    input wire logic rx_last_in, // Last byte of frame
    output logic rx_ready_out, // Byte may be offered
    output frame_queue_pkg::tx_word_type tx_word_out, // Word to transmit queue
    output logic tx_word_valid_out, // Word valid pulse
    output logic tx_overrun_out, // Write past frame end pulse
    output logic tx_underrun_out, // Frame aborted pulse
    input wire logic tx_egress_in, // Frame left transmit FIFO
    input wire logic [7:0] tx_egress_status_in, // Its status
    input wire logic [7:0] tx_egress_id_in, // Its frame id
    input wire logic [4*8-1:0] q_blocks_in, // Blocks held per queue
    input wire logic [3:0] q_eof_in, // Queue holds a whole frame
    output logic [3:0] queue_ready_flag_out, // Data ready per queue
    output logic [1:0] tx_sel_queue_out, // Chosen queue
    output logic tx_sel_valid_out, // Some queue is ready
    output logic [3:0] thr_irq_out // Threshold interrupt pulses
);
    localparam int NQ = frame_queue_pkg::NUM_TXQ;
    localparam int BW = frame_queue_pkg::BLK_W;
    localparam int CW = frame_queue_pkg::SETUP_CNT_W;

    // Decoded accesses
    logic wr_ctrl, wr_len, wr_data, wr_setup, rd_rx_stat, rd_rx_data, rd_tx_stat;
    logic [NQ-1:0] wr_qs;
    // Receive state
    logic [15:0] rx_cnt_r; // Head frame byte count
    logic rx_done_r; // Head frame complete
    logic rx_ready_r; // Byte accept window
    logic [1:0] rx_lane_r; // Next byte lane
    logic [31:0] rx_acc_r; // Word being packed
    logic rx_take; // Byte accepted this cycle
    logic rxf_in_valid;
    logic [31:0] rxf_in_data;
    logic rxf_out_valid;
    logic [31:0] rxf_out_data;
    logic [3:0] rxf_count;
    // Transmit state
    logic [15:0] remain_r; // Bytes still expected
    logic [7:0] frame_id_r; // Id from control word
    logic [CW-1:0] setup_cnt_r; // Writes left minus one
    logic [1:0] setup_so_r; // Start offset
    logic [1:0] setup_eo_r; // End offset
    logic setup_endian_r; // Big end first
    logic setup_on_r; // Setup applies to this frame
    logic first_r; // Next data write is first of block
    logic [3:0] keep; // Lanes sent this write
    logic [2:0] nbytes; // Bytes sent this write
    logic [31:0] ordered; // Bytes in send order
    logic txs_out_valid;
    logic [15:0] txs_out_data;
    // Queue state
    logic [1:0] mode_r [NQ];
    logic [BW-1:0] thr_r [NQ];
    logic [BW-1:0] blk_prev_r [NQ];

    // Address decode; writes and reads never overlap on this bus
    always_comb begin
        wr_ctrl = 1'b0;
        wr_len = 1'b0;
        wr_data = 1'b0;
        wr_setup = 1'b0;
        wr_qs = '0;
        rd_rx_stat = 1'b0;
        rd_rx_data = 1'b0;
        rd_tx_stat = 1'b0;
        if (host_wr_in && host_addr_in == frame_queue_pkg::TX_CTRL_OFS) begin
            wr_ctrl = 1'b1;
        end else if (host_wr_in && host_addr_in == frame_queue_pkg::TX_LEN_OFS) begin
            wr_len = 1'b1;
        end else if (host_wr_in && host_addr_in == frame_queue_pkg::TX_DATA_OFS) begin
            wr_data = 1'b1;
        end else if (host_wr_in && host_addr_in == frame_queue_pkg::TX_SETUP_OFS) begin
            wr_setup = 1'b1;
        end else if (host_wr_in && host_addr_in[7:4] == frame_queue_pkg::QSTATE_PAGE) begin
            wr_qs[host_addr_in[3:2]] = 1'b1;
        end else if (host_rd_in && host_addr_in == frame_queue_pkg::RX_STAT_OFS) begin
            rd_rx_stat = 1'b1;
        end else if (host_rd_in && (host_addr_in == frame_queue_pkg::RX_DATA_OFS ||
                     host_addr_in == frame_queue_pkg::RX_ALIAS_OFS)) begin
            rd_rx_data = 1'b1;
        end else if (host_rd_in && host_addr_in == frame_queue_pkg::TX_STAT_OFS) begin
            rd_tx_stat = 1'b1;
        end
    end

    assign rx_take = rx_byte_valid_in && rx_ready_r;
    // Ready leaves straight from its flop so the MAC sees no decode glitches
    assign rx_ready_out = rx_ready_r;

    // count grows only, cleared on pop
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            rx_cnt_r <= '0;
            rx_done_r <= 1'b0;
        end else if (rd_rx_stat && rx_done_r) begin
            rx_cnt_r <= '0;
            rx_done_r <= 1'b0;
        end else if (rx_take) begin
            rx_cnt_r <= rx_cnt_r + 16'h0001;
            rx_done_r <= rx_last_in;
        end
    end

    // Ready drops while a finished status waits or the FIFO nears full
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            rx_ready_r <= 1'b0;
        end else begin
            rx_ready_r <= !(rx_done_r && !rd_rx_stat) && !(rx_take && rx_last_in) &&
                          rxf_count < 4'h6;
        end
    end

    // pack bytes into words, zero pad the tail
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            rx_lane_r <= '0;
            rx_acc_r <= '0;
            rxf_in_valid <= 1'b0;
            rxf_in_data <= '0;
        end else begin
            rxf_in_valid <= 1'b0;
            if (rx_take) begin
                if (rx_lane_r == 2'h3 || rx_last_in) begin
                    rxf_in_valid <= 1'b1;
                    rxf_in_data <= rx_acc_r | ({24'h000000, rx_byte_in} << {rx_lane_r, 3'h0});
                    rx_acc_r <= '0;
                    rx_lane_r <= '0;
                end else begin
                    rx_acc_r <= rx_acc_r | ({24'h000000, rx_byte_in} << {rx_lane_r, 3'h0});
                    rx_lane_r <= rx_lane_r + 2'h1;
                end
            end
        end
    end

    // Receive data words; margin of two keeps pushes from meeting a full FIFO
    word_fifo #(.WIDTH(32), .DEPTH(frame_queue_pkg::FIFO_DEPTH)) rx_fifo (
        .clk_in(sys_clk_in),
        .reset_in(reset_in),
        .in_valid_in(rxf_in_valid),
        .in_ready_out(),
        .in_data_in(rxf_in_data),
        .out_valid_out(rxf_out_valid),
        .out_ready_in(rd_rx_data),
        .out_data_out(rxf_out_data),
        .count_out(rxf_count)
    );

    // egress status queued with its frame id
    word_fifo #(.WIDTH(16), .DEPTH(frame_queue_pkg::FIFO_DEPTH)) tx_stat_fifo (
        .clk_in(sys_clk_in),
        .reset_in(reset_in),
        .in_valid_in(tx_egress_in),
        .in_ready_out(),
        .in_data_in({tx_egress_status_in, tx_egress_id_in}),
        .out_valid_out(txs_out_valid),
        .out_ready_in(rd_tx_stat),
        .out_data_out(txs_out_data),
        .count_out()
    );

    // Byte lane selection for one data write
    always_comb begin
        logic [1:0] so;
        logic [1:0] eo;
        so = 2'h0;
        eo = 2'h0;
        nbytes = 3'h0;
        keep = 4'h0;
        // offsets only while a setup is active
        if (setup_on_r && first_r) begin
            so = setup_so_r;
        end
        // end offset holds while count is zero
        if (setup_on_r && setup_cnt_r == '0) begin
            eo = setup_eo_r;
        end
        for (int i = 0; i < 4; i++) begin
            // endian picks the first sent byte
            ordered[8*i +: 8] = setup_endian_r ? host_wdata_in[31-8*i -: 8] :
                                host_wdata_in[8*i +: 8];
            if (i >= so && i < 4 - eo && {13'h0000, nbytes} < remain_r) begin
                keep[i] = 1'b1;
                nbytes = nbytes + 3'h1;
            end
        end
    end

    // Frame length, id and word hand-off
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            remain_r <= '0;
            frame_id_r <= '0;
            tx_word_out <= '0;
            tx_word_valid_out <= 1'b0;
            tx_overrun_out <= 1'b0;
            tx_underrun_out <= 1'b0;
        end else begin
            tx_word_valid_out <= 1'b0;
            tx_overrun_out <= 1'b0;
            tx_underrun_out <= 1'b0;
            if (wr_ctrl) begin
                frame_id_r <= host_wdata_in[7:0];
                tx_underrun_out <= (remain_r != '0);
                remain_r <= '0;
            end else if (wr_len) begin
                remain_r <= host_wdata_in[15:0];
            end else if (wr_data) begin
                if (remain_r == '0) begin
                    tx_overrun_out <= 1'b1;
                end else begin
                    remain_r <= remain_r - {13'h0000, nbytes};
                    tx_word_valid_out <= 1'b1;
                    tx_word_out <= '{id: frame_id_r, last: (remain_r == {13'h0000, nbytes}),
                                     keep: keep, data: ordered};
                end
            end
        end
    end

    // Transfer setup register
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            setup_cnt_r <= '0;
            setup_so_r <= '0;
            setup_eo_r <= '0;
            setup_endian_r <= 1'b0;
            setup_on_r <= 1'b0;
            first_r <= 1'b0;
        end else if (wr_ctrl) begin
            setup_on_r <= 1'b0;
        end else if (wr_setup) begin
            setup_cnt_r <= host_wdata_in[frame_queue_pkg::SETUP_CNT_LSB +: CW];
            setup_so_r <= host_wdata_in[frame_queue_pkg::SETUP_SO_LSB +: 2];
            setup_eo_r <= host_wdata_in[frame_queue_pkg::SETUP_EO_LSB +: 2];
            setup_endian_r <= host_wdata_in[frame_queue_pkg::SETUP_ENDIAN_BIT];
            setup_on_r <= 1'b1;
            first_r <= 1'b1;
        end else if (wr_data) begin
            first_r <= 1'b0;
            if (setup_on_r && setup_cnt_r != '0) begin
                setup_cnt_r <= setup_cnt_r - 1'b1;
            end
        end
    end

    // Per-queue mode, threshold, ready flag and threshold interrupt
    for (genvar q = 0; q < NQ; q++) begin : g_queue
        logic [BW-1:0] blk;
        assign blk = q_blocks_in[q*BW +: BW];
        always_ff @(posedge sys_clk_in) begin
            if (reset_in) begin
                mode_r[q] <= frame_queue_pkg::MODE_ANY;
                thr_r[q] <= frame_queue_pkg::QS_THR_RESET;
                blk_prev_r[q] <= '0;
                queue_ready_flag_out[q] <= 1'b0;
                thr_irq_out[q] <= 1'b0;
            end else begin
                if (wr_qs[q]) begin
                    mode_r[q] <= host_wdata_in[frame_queue_pkg::QS_MODE_LSB +: 2];
                    thr_r[q] <= host_wdata_in[frame_queue_pkg::QS_THR_LSB +: BW];
                end
                blk_prev_r[q] <= blk;
                thr_irq_out[q] <= (blk < thr_r[q]) && (blk_prev_r[q] >= thr_r[q]);
                case (frame_queue_pkg::ready_mode_type'(mode_r[q]))
                    frame_queue_pkg::MODE_ANY: queue_ready_flag_out[q] <= (blk != '0);
                    frame_queue_pkg::MODE_THR: queue_ready_flag_out[q] <= (blk > thr_r[q]);
                    frame_queue_pkg::MODE_EOF: queue_ready_flag_out[q] <= q_eof_in[q];
                    default: queue_ready_flag_out[q] <= q_eof_in[q] || (blk > thr_r[q]);
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            tx_sel_queue_out <= '0;
            tx_sel_valid_out <= 1'b0;
        end else begin
            tx_sel_valid_out <= (queue_ready_flag_out != '0);
            tx_sel_queue_out <= '0;
            for (int i = NQ - 1; i >= 0; i--) begin
                if (queue_ready_flag_out[i]) begin
                    tx_sel_queue_out <= 2'(i);
                end
            end
        end
    end

    // Read data, returned the cycle after the strobe
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            host_rdata_out <= '0;
            host_rvalid_out <= 1'b0;
        end else begin
            host_rvalid_out <= host_rd_in;
            host_rdata_out <= '0;
            if (rd_rx_stat) begin
                host_rdata_out <= {rx_done_r, 15'h0000, rx_cnt_r};
            end else if (rd_rx_data) begin
                host_rdata_out <= rxf_out_valid ? rxf_out_data : 32'h00000000;
            end else if (rd_tx_stat) begin
                host_rdata_out <= {txs_out_valid, 15'h0000,
                                   txs_out_valid ? txs_out_data : 16'h0000};
            end else if (host_addr_in == frame_queue_pkg::TX_LEN_OFS) begin
                host_rdata_out <= {16'h0000, remain_r};
            end else if (host_addr_in == frame_queue_pkg::TX_SETUP_OFS) begin
                host_rdata_out <= {7'h00, setup_endian_r, 2'h0, setup_eo_r, 2'h0, setup_so_r,
                                   setup_cnt_r};
            end else if (host_addr_in[7:4] == frame_queue_pkg::QSTATE_PAGE) begin
                host_rdata_out <= {6'h00, mode_r[host_addr_in[3:2]], 7'h00,
                                   queue_ready_flag_out[host_addr_in[3:2]],
                                   q_blocks_in[host_addr_in[3:2]*BW +: BW],
                                   thr_r[host_addr_in[3:2]]};
            end
        end
    end

    // Checks
    sequence data_wr_s;
        wr_data && remain_r != '0;
    endsequence
    rx_count_grow_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        !(rd_rx_stat && rx_done_r) |=> rx_cnt_r >= $past(rx_cnt_r))
        else $error("rx count fell");
    rx_done_set_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        rx_take && rx_last_in |=> rx_done_r)
        else $error("done not set");
    rx_pop_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        rd_rx_stat && rx_done_r |=> rx_cnt_r == '0 && !rx_done_r)
        else $error("status not popped");
    tx_overrun_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        wr_data && remain_r == '0 |=> tx_overrun_out && !tx_word_valid_out)
        else $error("overrun missed");
    tx_underrun_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        wr_ctrl && remain_r != '0 |=> tx_underrun_out)
        else $error("underrun missed");
    tx_len_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        wr_len |=> remain_r == $past(host_wdata_in[15:0]))
        else $error("length not loaded");
    setup_cnt_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        data_wr_s ##0 (setup_on_r && setup_cnt_r != '0) |=> setup_cnt_r == $past(setup_cnt_r) - 1'b1)
        else $error("setup count stuck");
    q_sel_low_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        queue_ready_flag_out[0] |=> tx_sel_valid_out && tx_sel_queue_out == 2'h0)
        else $error("queue zero not chosen");
endmodule // host_frame_queue_access

// ==== hw/frame_queue_pkg.sv ====
// Purpose: Shared constants and types for the host frame queue access block
// Assumes: Host bus is synchronous to sys_clk_in; 32-bit register words
// Notes: Register offsets are byte addresses on the host bus
package frame_queue_pkg;
    // Host bus geometry
    localparam int ADDR_W = 8;
    localparam int NUM_TXQ = 4;
    localparam int FIFO_DEPTH = 8;
    // Register byte offsets
    localparam logic [7:0] RX_STAT_OFS = 8'h00;
    localparam logic [7:0] RX_DATA_OFS = 8'h04;
    localparam logic [7:0] RX_ALIAS_OFS = 8'h08;
    localparam logic [7:0] TX_CTRL_OFS = 8'h10;
    localparam logic [7:0] TX_LEN_OFS = 8'h14;
    localparam logic [7:0] TX_DATA_OFS = 8'h18;
    localparam logic [7:0] TX_STAT_OFS = 8'h1c;
    localparam logic [7:0] TX_SETUP_OFS = 8'h20;
    localparam logic [3:0] QSTATE_PAGE = 4'h4;
    // Receive status fields
    localparam int RX_CNT_W = 16;
    localparam int RX_DONE_BIT = 31;
    // Transfer setup fields
    localparam int SETUP_CNT_LSB = 0;
    localparam int SETUP_CNT_W = 16;
    localparam int SETUP_SO_LSB = 16;
    localparam int SETUP_EO_LSB = 20;
    localparam int SETUP_ENDIAN_BIT = 24;
    // Queue state fields
    localparam int QS_THR_LSB = 0;
    localparam int QS_BLK_LSB = 8;
    localparam int QS_RDY_BIT = 16;
    localparam int QS_MODE_LSB = 24;
    localparam int BLK_W = 8;
    localparam int TX_STAT_VALID_BIT = 31;
    // Reset values
    localparam logic [7:0] QS_THR_RESET = 8'h00;
    // Data-ready modes
    typedef enum logic [1:0] {
        MODE_ANY = 2'b00,
        MODE_THR = 2'b01,
        MODE_EOF = 2'b10,
        MODE_BOTH = 2'b11
    } ready_mode_type;
    // One host data word as handed to the transmitter, bytes in send order
    typedef struct packed {
        logic [7:0] id;
        logic last;
        logic [3:0] keep;
        logic [31:0] data;
    } tx_word_type;
endpackage

// ==== sim/mac_rx_model.sv ====
// Purpose: MAC receive side model offering frame bytes
// Assumes: A byte is taken at an edge where valid and ready are high
// Notes: Idle byte lane shows the inverse of the last byte
`timescale 1ns/100ps
module mac_rx_model (
    input wire logic clk_in, // Clock
    input wire logic ready_in, // Byte may be offered
    output logic valid_out, // Byte present
    output logic [7:0] byte_out, // Byte value
    output logic last_out // Final byte of frame
);
    initial {valid_out, byte_out, last_out} = 10'h0;
    // Send len bytes counting up from base, each held until taken
    task automatic send(input int len, input logic [7:0] base);
        @(posedge clk_in);
        for (int i = 0; i < len; i++) begin
            #1;
            {valid_out, last_out} = {1'b1, i == len - 1};
            byte_out = base + 8'(i);
            // Ready settled here is what the next edge samples
            while (ready_in !== 1'b1) begin
                @(posedge clk_in);
                #1;
            end
            @(posedge clk_in);
        end
        #1;
        {valid_out, last_out} = 2'b00;
        byte_out = ~byte_out;
    endtask
endmodule // mac_rx_model

// ==== sim/tb_top.sv ====
// Purpose: Self-checking bench for host frame queue access
// Assumes: One-cycle host strobes, read answer one cycle later
// Notes: Inputs move 1 ns after the rising edge to avoid races
`timescale 1ns/100ps
module tb_top;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, egr = 1'b0;
    logic [7:0] addr = 8'h00, rx_b;
    logic [31:0] wdata = 32'h0, rdata, qb = 32'h0;
    logic rvalid, rx_v, rx_l, rx_rdy, sel_v, ovr, unr, twv;
    logic [3:0] qe = 4'h0, qrdy, irq;
    logic [1:0] sel_q;
    frame_queue_pkg::tx_word_type tw;
    int fails = 0, samples_checked = 0, cyc = 0, n;
    initial forever #20 clk = ~clk;
    mac_rx_model i_mac (.clk_in(clk), .ready_in(rx_rdy), .valid_out(rx_v), .byte_out(rx_b),
        .last_out(rx_l));
    host_frame_queue_access i_dut (.sys_clk_in(clk), .reset_in(rst), .host_wr_in(wr),
        .host_rd_in(rd), .host_addr_in(addr), .host_wdata_in(wdata), .host_rdata_out(rdata),
        .host_rvalid_out(rvalid), .rx_byte_valid_in(rx_v), .rx_byte_in(rx_b),
        .rx_last_in(rx_l), .rx_ready_out(rx_rdy), .tx_word_out(tw), .tx_word_valid_out(twv),
        .tx_overrun_out(ovr), .tx_underrun_out(unr), .tx_egress_in(egr),
        .tx_egress_status_in(8'h77), .tx_egress_id_in(tw.id), .q_blocks_in(qb),
        .q_eof_in(qe), .queue_ready_flag_out(qrdy), .tx_sel_queue_out(sel_q),
        .tx_sel_valid_out(sel_v), .thr_irq_out(irq));
    // Compare and count; unknowns never match
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    // Host write: strobe held for exactly one edge
    task automatic hw(input logic [7:0] a, input logic [31:0] v);
        step(1);
        {wr, addr, wdata} = {1'b1, a, v};
        step(1);
        wr = 1'b0;
    endtask
    // Host read: data is only trusted with its valid pulse
    task automatic hr(input logic [7:0] a, input logic [31:0] exp);
        step(1);
        {rd, addr} = {1'b1, a};
        step(1);
        rd = 1'b0;
        chk((rvalid === 1'b1) ? rdata : 32'hx, exp);
    endtask
    task automatic tword(input logic [3:0] k, input logic l);
        chk({26'h0, twv, tw.last, tw.keep}, {26'h0, 1'b1, l, k});
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Hang guard; the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fails++;
            print_verdict();
        end
    end
    initial begin
        step(3);
        rst = 1'b0;
        hr(8'h40, 32'h0);
        i_mac.send(5, 8'h11);
        step(2);
        chk({31'h0, rx_rdy}, 32'h0);
        hr(8'h00, 32'h80000005);
        chk({31'h0, rx_rdy}, 32'h1);
        hr(8'h00, 32'h0);
        hr(8'h04, 32'h14131211);
        hr(8'h08, 32'h00000015);
        $display("test rx done");
        hw(8'h10, 32'h5a);
        hw(8'h14, 32'd6);
        hw(8'h18, 32'h44332211);
        tword(4'hf, 1'b0);
        chk({24'h0, tw.id}, 32'h5a);
        hw(8'h18, 32'h88776655);
        tword(4'h3, 1'b1);
        hw(8'h18, 32'h0);
        chk({31'h0, ovr}, 32'h1);
        hr(8'h14, 32'h0);
        // Abort a frame mid-way, then clip the next one by rewriting length
        hw(8'h10, 32'h01);
        hw(8'h14, 32'd8);
        hw(8'h18, 32'h0);
        hr(8'h14, 32'd4);
        hw(8'h10, 32'h02);
        chk({31'h0, unr}, 32'h1);
        hw(8'h14, 32'd9);
        hw(8'h14, 32'd1);
        hw(8'h18, 32'hffffffff);
        tword(4'h1, 1'b1);
        $display("test tx length done");
        // Two-write block, start offset 2, end offset 3
        hw(8'h10, 32'h03);
        hw(8'h14, 32'd100);
        hw(8'h20, 32'h00320001);
        hw(8'h18, 32'h0);
        tword(4'hc, 1'b0);
        hr(8'h20, 32'h00320000);
        hw(8'h18, 32'h0);
        tword(4'h1, 1'b0);
        hw(8'h18, 32'h0);
        tword(4'h1, 1'b0);
        hw(8'h20, 32'h01000000);
        hw(8'h18, 32'h11223344);
        chk(tw.data, 32'h44332211);
        step(1);
        egr = 1'b1;
        step(1);
        egr = 1'b0;
        hr(8'h1c, 32'h80007703);
        $display("test tx setup done");
        // Every mode against blocks 0, 2, 3 (threshold 2) and eof
        for (int m = 0; m < 4; m++) begin
            hw(8'h40, {6'h0, m[1:0], 24'h000002});
            for (int b = 0; b < 6; b++) begin
                qb = {24'h0, (b < 2) ? 8'h00 : (b < 4) ? 8'h02 : 8'h03};
                qe = {3'h0, b[0]};
                step(3);
                n = (m == 0) ? int'(qb[7:0] != 0) : (m == 1) ? int'(qb[7:0] > 2) :
                    (m == 2) ? int'(qe[0]) : int'(qe[0] || qb[7:0] > 2);
                chk({31'h0, qrdy[0]}, n);
            end
        end
        hw(8'h40, 32'h02);
        qe = 4'h0;
        step(3);
        qb = 32'h01;
        n = 0;
        repeat (4) begin
            step(1);
            n += int'(irq[0] === 1'b1);
        end
        chk(n, 1);
        qb = 32'h01000100;
        step(3);
        chk({29'h0, sel_v, sel_q}, 32'h5);
        $display("test queues done");
        print_verdict();
    end
endmodule // tb_top
